// ---- verilog/csvm_defs.svh ----
// constants for current scaling and velocity mode selection
`ifndef CSVM_DEFS_SVH
`define CSVM_DEFS_SVH
`define CSVM_SCALE_W 5
`define CSVM_IVAL_W 20
`define CSVM_IVAL_MAX 20'hfffff
`define CSVM_STST_CLOCKS (1 << 20)
`define CSVM_RAMP_UNIT_CLOCKS (1 << 18)
`define CSVM_GS_FULL 9'h100
`define CSVM_COIL_SHIFT 13
`define CSVM_HYST_WIDE 4
`define CSVM_HYST_NARROW 5
`endif

// ---- verilog/csvm_pkg.sv ----
// types shared by the current scaling and mode selection block
`default_nettype none
`include "csvm_defs.svh"
package csvm_pkg;
    typedef logic [`CSVM_SCALE_W-1:0] scale_t;
    typedef logic [`CSVM_IVAL_W-1:0] interval_t;
    typedef struct packed {
        scale_t run_current_scale;
        scale_t hold_current_scale;
        logic [3:0] hold_ramp_delay;
        logic [7:0] zero_wait_delay;
        logic [7:0] global_current_scaler;
    } current_cfg_t;
    typedef struct packed {
        interval_t quiet_mode_interval_limit;
        interval_t high_speed_interval_limit;
        interval_t load_adapt_interval_limit;
        logic narrow_hysteresis;
        logic quiet_mode_enable;
        logic load_adapt_enable;
    } thresh_cfg_t;
    typedef struct packed {
        logic quiet_mode;
        logic high_speed;
        logic load_adapt;
    } mode_flags_t;
    typedef enum logic [1:0] {S_RUN, S_ZWAIT, S_RAMP, S_HOLD} ramp_state_t;
endpackage
`default_nettype wire

// ---- verilog/interval_threshold_compare.sv ----
// one step interval threshold comparison with hysteresis
`timescale 1ns/100ps
`default_nettype none
`include "csvm_defs.svh"
module interval_threshold_compare import csvm_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // comparison inputs
    input wire interval_t interval,
    input wire interval_t threshold,
    input wire logic narrow,
    // result: velocity above threshold
    output logic below
);
    logic below_q;
    logic below_d;
    interval_t thr_frac;
    interval_t entry_thr;
    wire entry_ok;

    assign thr_frac = narrow ? (threshold >> `CSVM_HYST_NARROW)
                             : (threshold >> `CSVM_HYST_WIDE);
    // entering needs threshold*15/16-1 (or 31/32-1), leaving needs threshold itself
    assign entry_thr = threshold - thr_frac - interval_t'(1);
    // a zero limit never engages, avoiding the underflow of entry_thr
    assign entry_ok = threshold != '0;
    assign below_d = below_q ? (interval <= threshold)
                             : (entry_ok && interval <= entry_thr);
    assign below = below_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            below_q <= 1'b0;
        end else begin
            below_q <= below_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_enter;
        !below_q && entry_ok && interval <= entry_thr |=> below_q;
    endproperty
    a_enter: assert property (p_enter) else $error("compare did not engage");
    property p_no_early_enter;
        !below_q && interval > entry_thr |=> !below_q;
    endproperty
    a_no_early_enter: assert property (p_no_early_enter)
        else $error("compare engaged inside hysteresis band");
    property p_leave;
        below_q && interval > threshold |=> !below_q;
    endproperty
    a_leave: assert property (p_leave) else $error("compare did not release");
endmodule // interval_threshold_compare
`default_nettype wire

// ---- verilog/current_scale_velocity_mode_select.sv ----
// run and hold current scaling, step interval measurement, velocity mode selection
`timescale 1ns/100ps
`default_nettype none
`include "csvm_defs.svh"
module current_scale_velocity_mode_select import csvm_pkg::*; #(
    parameter int unsigned STST_CLOCKS = `CSVM_STST_CLOCKS,
    parameter int unsigned RAMP_UNIT_CLOCKS = `CSVM_RAMP_UNIT_CLOCKS
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // step source, internal ramp or external
    input wire logic step_pulse,
    input wire logic [3:0] microstep_shift,
    // current settings
    input wire current_cfg_t current_cfg,
    input wire scale_t load_adapt_request,
    // velocity thresholds
    input wire thresh_cfg_t thresh_cfg,
    // sine table values
    input wire logic signed [8:0] sine_a,
    input wire logic signed [8:0] sine_b,
    // status and results
    output logic standstill,
    output interval_t step_interval,
    output scale_t current_scale,
    output mode_flags_t mode_flags,
    output logic signed [8:0] coil_a,
    output logic signed [8:0] coil_b
);
    // wide enough for the saturated idle count and for the full interval range
    localparam int IDLE_W = ($clog2(STST_CLOCKS) > `CSVM_IVAL_W) ? $clog2(STST_CLOCKS) + 1
                                                                 : `CSVM_IVAL_W + 1;
    localparam int UNIT_W = $clog2(RAMP_UNIT_CLOCKS);

    // sine * (cs+1)/32 * gs/256, zero global scaler meaning 256
    function automatic logic signed [8:0] scale_coil(input logic signed [8:0] cur,
                                                     input scale_t cs,
                                                     input logic [7:0] gs);
        logic [8:0] gsf;
        logic [5:0] cs1;
        logic signed [24:0] prod;
        gsf = (gs == 8'h00) ? `CSVM_GS_FULL : {1'b0, gs};
        cs1 = {1'b0, cs} + 6'h01;
        prod = 25'(cur) * $signed({19'h0, cs1});
        prod = prod * $signed({16'h0, gsf});
        scale_coil = 9'(prod >>> `CSVM_COIL_SHIFT);
    endfunction

    logic [IDLE_W-1:0] idle_q;
    logic [IDLE_W-1:0] idle_d;
    logic stst_q;
    logic stst_d;
    interval_t measured_q;
    interval_t measured_d;
    interval_t interval_q;
    interval_t interval_d;
    interval_t raw_count;
    wire idle_sat;
    wire overflow;

    // saturate rather than wrap so a long pause never looks like a fast step
    assign idle_sat = idle_q == IDLE_W'(STST_CLOCKS);
    assign idle_d = step_pulse ? IDLE_W'(1) : (idle_sat ? idle_q : idle_q + IDLE_W'(1));
    assign overflow = idle_q >= IDLE_W'(`CSVM_IVAL_MAX);
    assign raw_count = overflow ? `CSVM_IVAL_MAX : idle_q[`CSVM_IVAL_W-1:0];
    // coarser microsteps span 2^shift fine steps each
    assign measured_d = step_pulse ? (raw_count >> microstep_shift) : measured_q;
    assign stst_d = !step_pulse && (stst_q || idle_sat);
    assign interval_d = (stst_d || (overflow && !step_pulse)) ? `CSVM_IVAL_MAX
                                                              : measured_d;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            idle_q <= '0;
            stst_q <= 1'b0;
            measured_q <= `CSVM_IVAL_MAX;
            interval_q <= `CSVM_IVAL_MAX;
        end else begin
            idle_q <= idle_d;
            stst_q <= stst_d;
            measured_q <= measured_d;
            interval_q <= interval_d;
        end
    end

    // velocity threshold comparisons
    logic quiet_below;
    logic high_below;
    logic load_below;
    mode_flags_t mode_q;
    mode_flags_t mode_d;

    interval_threshold_compare u_cmp_quiet (
        .clock(clock),
        .rst(rst),
        .interval(interval_q),
        .threshold(thresh_cfg.quiet_mode_interval_limit),
        .narrow(thresh_cfg.narrow_hysteresis),
        .below(quiet_below)
    );
    interval_threshold_compare u_cmp_high (
        .clock(clock),
        .rst(rst),
        .interval(interval_q),
        .threshold(thresh_cfg.high_speed_interval_limit),
        .narrow(thresh_cfg.narrow_hysteresis),
        .below(high_below)
    );
    interval_threshold_compare u_cmp_load (
        .clock(clock),
        .rst(rst),
        .interval(interval_q),
        .threshold(thresh_cfg.load_adapt_interval_limit),
        .narrow(thresh_cfg.narrow_hysteresis),
        .below(load_below)
    );

    assign mode_d.quiet_mode = thresh_cfg.quiet_mode_enable && !quiet_below;
    assign mode_d.high_speed = high_below;
    assign mode_d.load_adapt = thresh_cfg.load_adapt_enable && load_below && !high_below;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q <= '0;
        end else begin
            mode_q <= mode_d;
        end
    end

    // hold current ramp
    ramp_state_t st_q;
    ramp_state_t st_d;
    scale_t ramp_q;
    scale_t ramp_d;
    scale_t cs_q;
    scale_t cs_d;
    scale_t run_capped;
    logic [7:0] ticks_q;
    logic [7:0] ticks_d;
    logic [UNIT_W-1:0] unit_q;
    logic [UNIT_W-1:0] unit_d;
    logic signed [8:0] coil_a_q;
    logic signed [8:0] coil_b_q;
    wire tick;
    wire step_due;

    assign tick = unit_q == UNIT_W'(RAMP_UNIT_CLOCKS - 1);
    assign unit_d = (st_q == S_RUN || tick) ? '0 : unit_q + UNIT_W'(1);
    assign step_due = (ticks_q + 8'h01) >= {4'h0, current_cfg.hold_ramp_delay};

    always_comb begin
        st_d = st_q;
        ramp_d = ramp_q;
        ticks_d = ticks_q;
        case (st_q)
            S_RUN: begin
                ramp_d = current_cfg.run_current_scale;
                if (stst_q) begin
                    st_d = S_ZWAIT;
                    ticks_d = 8'h00;
                end
            end
            S_ZWAIT: begin
                if (ticks_q >= current_cfg.zero_wait_delay) begin
                    st_d = S_RAMP;
                    ticks_d = 8'h00;
                end else if (tick) begin
                    ticks_d = ticks_q + 8'h01;
                end
            end
            S_RAMP: begin
                if (current_cfg.hold_ramp_delay == 4'h0 ||
                    ramp_q <= current_cfg.hold_current_scale) begin
                    ramp_d = current_cfg.hold_current_scale;
                    st_d = S_HOLD;
                end else if (tick && step_due) begin
                    ramp_d = ramp_q - scale_t'(1);
                    ticks_d = 8'h00;
                end else if (tick) begin
                    ticks_d = ticks_q + 8'h01;
                end
            end
            S_HOLD: begin
                ramp_d = current_cfg.hold_current_scale;
            end
            default: begin
                st_d = S_RUN;
            end
        endcase
        if (step_pulse) begin
            st_d = S_RUN;
            ramp_d = current_cfg.run_current_scale;
        end
    end

    // load-adaptive request may lower the current but never exceed run scale
    assign run_capped = (load_adapt_request < current_cfg.run_current_scale)
                        ? load_adapt_request : current_cfg.run_current_scale;
    assign cs_d = (st_q != S_RUN) ? ramp_q
                : (mode_q.load_adapt ? run_capped : current_cfg.run_current_scale);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= S_RUN;
            ramp_q <= '0;
            ticks_q <= 8'h00;
            unit_q <= '0;
            cs_q <= '0;
        end else begin
            st_q <= st_d;
            ramp_q <= ramp_d;
            ticks_q <= ticks_d;
            unit_q <= unit_d;
            cs_q <= cs_d;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            coil_a_q <= '0;
            coil_b_q <= '0;
        end else begin
            coil_a_q <= scale_coil(sine_a, cs_q, current_cfg.global_current_scaler);
            coil_b_q <= scale_coil(sine_b, cs_q, current_cfg.global_current_scaler);
        end
    end

    assign standstill = stst_q;
    assign step_interval = interval_q;
    assign current_scale = cs_q;
    assign mode_flags = mode_q;
    assign coil_a = coil_a_q;
    assign coil_b = coil_b_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_stst_rise;
        !step_pulse && idle_q == IDLE_W'(STST_CLOCKS - 1)
            |=> !stst_q ##1 (stst_q || $past(step_pulse));
    endproperty
    a_stst_rise: assert property (p_stst_rise) else $error("standstill late");
    property p_stst_clear;
        step_pulse |=> !stst_q && st_q == S_RUN;
    endproperty
    a_stst_clear: assert property (p_stst_clear) else $error("step did not end standstill");
    property p_interval_max;
        stst_q |-> step_interval == `CSVM_IVAL_MAX;
    endproperty
    a_interval_max: assert property (p_interval_max) else $error("interval not max");
    property p_measure;
        step_pulse && !stst_q && !overflow
            |=> measured_q == ($past(raw_count) >> $past(microstep_shift));
    endproperty
    a_measure: assert property (p_measure) else $error("interval measure wrong");
    property p_run_restore;
        step_pulse |=> ramp_q == $past(current_cfg.run_current_scale);
    endproperty
    a_run_restore: assert property (p_run_restore) else $error("run scale not restored");
    property p_hold_stays;
        st_q == S_HOLD && !step_pulse |=> ramp_q == $past(current_cfg.hold_current_scale);
    endproperty
    a_hold_stays: assert property (p_hold_stays) else $error("hold scale lost");
    property p_instant;
        st_q == S_RAMP && current_cfg.hold_ramp_delay == 4'h0 && !step_pulse
            |=> st_q == S_HOLD && ramp_q == $past(current_cfg.hold_current_scale);
    endproperty
    a_instant: assert property (p_instant) else $error("instant hold failed");
    property p_cap;
        st_q == S_RUN |-> cs_d <= current_cfg.run_current_scale;
    endproperty
    a_cap: assert property (p_cap) else $error("scale above run scale");
    property p_full_scale;
        cs_q == 5'h1f && current_cfg.global_current_scaler == 8'h00 |=> coil_a_q == $past(sine_a);
    endproperty
    a_full_scale: assert property (p_full_scale) else $error("full scale not unity");
    property p_load_window;
        // the mode flags trail the interval by two cycles
        mode_q.load_adapt |-> !mode_q.high_speed && !$past(stst_q, 2);
    endproperty
    a_load_window: assert property (p_load_window) else $error("load adapt outside window");

    c_hold_reached: cover property (st_q == S_RAMP ##1 st_q == S_HOLD);
    c_load_adapt: cover property (mode_q.load_adapt && st_q == S_RUN);
    c_high_speed: cover property (mode_q.high_speed);
    c_ramp_step: cover property (st_q == S_RAMP && tick && step_due);
endmodule // current_scale_velocity_mode_select
`default_nettype wire

// ---- bench/step_source_model.sv ----
// step pulse source standing in for the ramp generator or an external step input
`timescale 1ns/100ps
`default_nettype none
module step_source_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control from the bench
    input wire logic en,
    input wire logic [15:0] period,
    // step output
    output logic step_pulse
);
    logic [15:0] count_q;

    // a disabled source preloads its count so the first pulse follows enable at once
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            count_q <= 16'h0000;
            step_pulse <= #1 1'b0;
        end else if (!en) begin
            count_q <= period - 16'h0001;
            step_pulse <= #1 1'b0;
        end else if (count_q >= period - 16'h0001) begin
            count_q <= 16'h0000;
            step_pulse <= #1 1'b1;
        end else begin
            count_q <= count_q + 16'h0001;
            step_pulse <= #1 1'b0;
        end
    end
endmodule // step_source_model
`default_nettype wire

// ---- bench/current_scale_velocity_mode_select_tb.sv ----
// self-checking bench for current scaling and velocity mode selection
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
    check_count++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end
module current_scale_velocity_mode_select_tb import csvm_pkg::*;;
    // shortened counts keep the run short; expectations follow these values
    localparam int unsigned STST = 2048;
    localparam int unsigned RAMP = 16;
    typedef struct {
        logic [15:0] period;
        logic [3:0] shift;
        scale_t req;
        interval_t iv;
        mode_flags_t flags;
        scale_t cs;
    } row_t;
    logic clock, rst, en, step_pulse, standstill;
    logic [15:0] period;
    logic [3:0] shift;
    current_cfg_t ccfg;
    thresh_cfg_t tcfg;
    scale_t req, current_scale;
    logic signed [8:0] sine_a, sine_b, coil_a, coil_b;
    interval_t step_interval;
    mode_flags_t mode_flags;
    row_t rows [0:9];
    int fail_count = 0;
    int check_count = 0;
    int i, v, n;

    always #5 clock = ~clock;

    step_source_model u_src (.clock(clock), .rst(rst), .en(en), .period(period),
        .step_pulse(step_pulse));

    current_scale_velocity_mode_select #(.STST_CLOCKS(STST), .RAMP_UNIT_CLOCKS(RAMP)) u_dut (
        .clock(clock), .rst(rst), .step_pulse(step_pulse), .microstep_shift(shift),
        .current_cfg(ccfg), .load_adapt_request(req), .thresh_cfg(tcfg),
        .sine_a(sine_a), .sine_b(sine_b), .standstill(standstill),
        .step_interval(step_interval), .current_scale(current_scale),
        .mode_flags(mode_flags), .coil_a(coil_a), .coil_b(coil_b));

    task automatic print_verdict();
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // returns at the edge that samples a step
    task automatic wait_step();
        int k;
        k = 0;
        @(posedge clock);
        while (step_pulse !== 1'b1 && k < 3000) begin
            @(posedge clock);
            k++;
        end
        if (k >= 3000) begin
            fail_count++;
            print_verdict();
        end
    endtask

    initial begin
        // hysteresis worked out by hand: high 100 engages at 93, load 400 at 374, quiet 800 at 749
        rows = '{'{16'd50, 4'd0, 5'h1f, 20'd50, 3'b010, 5'h18},
                 '{16'd200, 4'd0, 5'h14, 20'd200, 3'b001, 5'h14},
                 '{16'd200, 4'd0, 5'h1f, 20'd200, 3'b001, 5'h18},
                 '{16'd600, 4'd0, 5'h1f, 20'd600, 3'b000, 5'h18},
                 '{16'd1000, 4'd0, 5'h1f, 20'd1000, 3'b100, 5'h18},
                 '{16'd400, 4'd2, 5'h1f, 20'd100, 3'b001, 5'h18},
                 '{16'd380, 4'd2, 5'h1f, 20'd95, 3'b001, 5'h18},
                 '{16'd360, 4'd2, 5'h1f, 20'd90, 3'b010, 5'h18},
                 '{16'd400, 4'd2, 5'h1f, 20'd100, 3'b010, 5'h18},
                 '{16'd404, 4'd2, 5'h1f, 20'd101, 3'b001, 5'h18}};
        clock = 1'b0;
        rst = 1'b1;
        en = 1'b0;
        period = 16'd50;
        shift = 4'h0;
        req = 5'h1f;
        sine_a = 9'h0f8;
        sine_b = 9'h19c;
        ccfg.run_current_scale = 5'h18;
        ccfg.hold_current_scale = 5'h12;
        ccfg.hold_ramp_delay = 4'h1;
        ccfg.zero_wait_delay = 8'h02;
        ccfg.global_current_scaler = 8'h00;
        tcfg.quiet_mode_interval_limit = 20'd800;
        tcfg.high_speed_interval_limit = 20'd100;
        tcfg.load_adapt_interval_limit = 20'd400;
        tcfg.narrow_hysteresis = 1'b0;
        tcfg.quiet_mode_enable = 1'b1;
        tcfg.load_adapt_enable = 1'b1;
        repeat (8) @(posedge clock);
        `CHK(step_interval, 20'hfffff)
        `CHK(standstill, 1'b0)
        `CHK(current_scale, 5'h00)
        `CHK(mode_flags, 3'b000)
        `CHK(coil_a, 9'h000)
        #1 rst = 1'b0;
        repeat (2) @(posedge clock);
        #1 `CHK(current_scale, 5'h18)
        for (i = 0; i < 10; i++) begin
            period = rows[i].period;
            shift = rows[i].shift;
            req = rows[i].req;
            en = 1'b1;
            repeat (5) wait_step();
            repeat (4) @(posedge clock);
            #1 `CHK(step_interval, rows[i].iv)
            `CHK(mode_flags, rows[i].flags)
            `CHK(current_scale, rows[i].cs)
        end
        // 96 engages the high limit only with the narrow band (entry 96 against 93)
        tcfg.narrow_hysteresis = 1'b1;
        period = 16'd384;
        repeat (5) wait_step();
        repeat (4) @(posedge clock);
        #1 `CHK(mode_flags, 3'b010)
        `CHK(coil_a, 9'h0c1)
        `CHK(coil_b, 9'h1b1)
        ccfg.global_current_scaler = 8'h80;
        repeat (4) @(posedge clock);
        #1 `CHK(coil_a, 9'h060)
        `CHK(coil_b, 9'h1d8)
        wait_step();
        #1 en = 1'b0;
        repeat (STST - 1) @(posedge clock);
        #1 `CHK(standstill, 1'b0)
        @(posedge clock);
        #1 `CHK(standstill, 1'b1)
        repeat (4) @(posedge clock);
        #1 `CHK(step_interval, 20'hfffff)
        `CHK(mode_flags, 3'b100)
        repeat (24) @(posedge clock);
        #1 `CHK(current_scale, 5'h18)
        for (v = 23; v >= 18; v--) begin
            n = 0;
            while (current_scale !== scale_t'(v) && n < 40) begin
                @(posedge clock);
                #1 n++;
            end
            `CHK(current_scale, scale_t'(v))
            if (v < 23) begin
                `CHK(n >= 15 && n <= 17, 1'b1)
            end
        end
        repeat (40) @(posedge clock);
        #1 `CHK(current_scale, 5'h12)
        en = 1'b1;
        wait_step();
        #1 en = 1'b0;
        repeat (2) @(posedge clock);
        #1 `CHK(current_scale, 5'h18)
        `CHK(standstill, 1'b0)
        // a gradual ramp would still sit near run scale here, an instant one at hold
        ccfg.hold_ramp_delay = 4'h0;
        repeat (STST + 38) @(posedge clock);
        #1 `CHK(current_scale, 5'h12)
        ccfg.global_current_scaler = 8'h00;
        ccfg.hold_current_scale = 5'h1f;
        repeat (4) @(posedge clock);
        #1 `CHK(current_scale, 5'h1f)
        `CHK(coil_a, 9'h0f8)
        `CHK(coil_b, 9'h19c)
        print_verdict();
    end
endmodule // current_scale_velocity_mode_select_tb
`default_nettype wire
